//--- mbc_consts.vh
`ifndef MBC_CONSTS_VH
`define MBC_CONSTS_VH
`define MBC_OFFSET 8'hf0
`define MBC_RESET 32'h0000_0800
`define MBC_WR_MASK 32'h0000_f79f
`define MBC_BIT_DEEP_OFF 15
`define MBC_PWR_HI 14
`define MBC_PWR_LO 12
`define MBC_BIT_REV_CONF 11
`define MBC_BIT_PME_SKIP 10
`define MBC_BRC_HI 9
`define MBC_BRC_LO 8
`define MBC_BIT_PM_REV 7
`define MBC_BIT_NO_ABORT 4
`define MBC_BIT_TWOWIRE 3
`define MBC_BIT_LINK_BYP 2
`define MBC_BIT_HOST_BYP 1
`define MBC_BIT_KEEP_CLK 0
`define MBC_PM_REV_OLD 3'h2
`define MBC_PM_REV_NEW 3'h3
`define MBC_CMD_MEM_READ 4'h6
`define MBC_CMD_READ_LINE 4'he
`define MBC_CMD_READ_MULT 4'hc
`define MBC_EE_WORD 8'h0c
`define MBC_INACTIVE_DATA 32'hffff_ffff
`endif

//--- mbc_burst_cmd.v
`timescale 1ns/1ps
`include "mbc_consts.vh"
module mbc_burst_cmd (
    input wire clk_i,
    input wire resetn_i,
    input wire [1:0] sel_i,
    input wire long_read_i,
    output reg [3:0] cmd_o
);
    // registered command choice for the master read engine
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            cmd_o <= `MBC_CMD_MEM_READ;
        end else if (!long_read_i) begin
            // RULE8 short reads plain
            cmd_o <= `MBC_CMD_MEM_READ;
        end else begin
            // RULE7 burst command select
            case (sel_i)
                2'b01: cmd_o <= `MBC_CMD_MEM_READ;
                2'b10: cmd_o <= `MBC_CMD_READ_MULT;
                default: cmd_o <= `MBC_CMD_READ_LINE; // reserved code acts as default
            endcase
        end
    end
endmodule

//--- mbc_pme_gate.v
`timescale 1ns/1ps
module mbc_pme_gate (
    input wire clk_i,
    input wire resetn_i,
    input wire skip_gate_i,
    input wire global_irq_enable_i,
    input wire unmasked_irq_i,
    output reg pme_req_o
);
    // RULE5 pme gating choice
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            pme_req_o <= 1'b0;
        end else begin
            pme_req_o <= unmasked_irq_i & (skip_gate_i | global_irq_enable_i);
        end
    end
endmodule

//--- mbc_misc_reg.v
`timescale 1ns/1ps
`include "mbc_consts.vh"
// What this block does
// RULE1 - upper sixteen bits read zero
// RULE2 - bit 15 feeds capability bit 15
// RULE3 - bits 14-12 drive power-level pins
// RULE4 - bit 11 always reads one
// RULE5 - bit 10 drops global irq gate
// RULE6 - bit 10 mirrored to vendor bit 26
// RULE7 - bits 9-8 pick long read command
// RULE8 - short reads use plain memory read
// RULE9 - eeprom word 12 loads bits 9-8
// RULE10 - bit 7 picks pm revision 010/011
// RULE11 - bits 6 and 5 read zero
// RULE12 - inactive link access aborts by default
// RULE13 - bit 4 returns ones, no abort
// RULE14 - software keeps bit 4 clear
// RULE15 - bit 3 routes io lines to two-wire
// RULE16 - bit 2 bypasses link clock gate
// RULE17 - bit 1 bypasses host clock gate
// RULE18 - bit 0 keeps host clock running
// RULE19 - only global reset clears bits
// RULE20 - reset value 0000_0800
// RULE21 - read-only bits ignore writes
module mbc_misc_reg (
    input wire clk_i,
    input wire resetn_i,
    input wire cfg_wr_i,
    input wire cfg_rd_i,
    input wire [7:0] cfg_addr_i,
    input wire [3:0] cfg_be_i,
    input wire [31:0] cfg_wdata_i,
    output reg [31:0] cfg_rdata_o,
    output wire cfg_hit_o,
    input wire ee_load_i,
    input wire [7:0] ee_word_i,
    input wire [15:0] ee_data_i,
    input wire global_irq_enable_i,
    input wire unmasked_irq_i,
    output wire pme_req_o,
    input wire long_read_i,
    output wire [3:0] read_cmd_o,
    input wire link_access_i,
    input wire link_clk_active_i,
    output wire link_abort_o,
    output reg [31:0] link_rdata_o,
    input wire [31:0] link_core_rdata_i,
    output wire pme_from_deep_off_support_o,
    output wire [2:0] pm_revision_field_o,
    output wire vendor_id_bit26_o,
    output wire power_level_pin_2_o,
    output wire power_level_pin_1_o,
    output wire power_level_pin_0_o,
    input wire general_io_line_three_i,
    input wire general_io_line_two_i,
    input wire general_io_line_three_drv_i,
    input wire general_io_line_two_drv_i,
    input wire general_io_line_three_oen_n_i,
    input wire general_io_line_two_oen_n_i,
    output wire general_io_line_three_o,
    output wire general_io_line_two_o,
    output wire general_io_line_three_oe_n_o,
    output wire general_io_line_two_oe_n_o,
    output wire twowire_clk_o,
    output wire twowire_data_o,
    output wire twowire_route_o,
    output wire link_clk_gate_bypass_o,
    output wire host_clk_gate_bypass_o,
    output wire keep_host_clk_o
);
    reg [31:0] reg_q;
    reg [31:0] reg_d;
    wire [31:0] wmask;
    wire [31:0] read_val;
    integer i;

    assign cfg_hit_o = (cfg_addr_i == `MBC_OFFSET);

    // byte enables widened to a bit mask, limited to writable bits
    assign wmask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}}
        & `MBC_WR_MASK;

    // next value: config write, then eeprom load of the burst field
    always @* begin
        reg_d = reg_q;
        if (cfg_wr_i && cfg_hit_o) begin
            // RULE21 read-only bits kept
            for (i = 0; i < 32; i = i + 1) begin
                if (wmask[i]) begin
                    reg_d[i] = cfg_wdata_i[i];
                end
            end
        end
        // RULE9 eeprom loads burst field
        if (ee_load_i && ee_word_i == `MBC_EE_WORD) begin
            reg_d[`MBC_BRC_HI:`MBC_BRC_LO] = ee_data_i[1:0];
        end
        // RULE4 conformance bit fixed
        reg_d[`MBC_BIT_REV_CONF] = 1'b1;
    end

    // resetn_i is the global reset input; ordinary bus reset is not wired here
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            // RULE19 global reset only
            // RULE20 reset value
            reg_q <= `MBC_RESET;
        end else begin
            reg_q <= reg_d;
        end
    end

    // RULE1 upper half zero
    // RULE11 bits 6-5 zero
    assign read_val = reg_q & (`MBC_WR_MASK | `MBC_RESET);

    // read data registered for the config cycle
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            cfg_rdata_o <= 32'h0000_0000;
        end else if (cfg_rd_i) begin
            cfg_rdata_o <= cfg_hit_o ? read_val : 32'h0000_0000;
        end
    end

    // RULE2 deep-off pme support
    assign pme_from_deep_off_support_o = reg_q[`MBC_BIT_DEEP_OFF];
    // RULE10 pm revision select
    assign pm_revision_field_o = reg_q[`MBC_BIT_PM_REV] ? `MBC_PM_REV_NEW : `MBC_PM_REV_OLD;
    // RULE6 vendor id mirror
    assign vendor_id_bit26_o = reg_q[`MBC_BIT_PME_SKIP];
    // RULE3 power level pins
    assign power_level_pin_2_o = reg_q[`MBC_PWR_HI];
    assign power_level_pin_1_o = reg_q[`MBC_PWR_LO + 1];
    assign power_level_pin_0_o = reg_q[`MBC_PWR_LO];

    mbc_pme_gate u_pme (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .skip_gate_i(reg_q[`MBC_BIT_PME_SKIP]),
        .global_irq_enable_i(global_irq_enable_i),
        .unmasked_irq_i(unmasked_irq_i),
        .pme_req_o(pme_req_o)
    );

    mbc_burst_cmd u_cmd (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .sel_i(reg_q[`MBC_BRC_HI:`MBC_BRC_LO]),
        .long_read_i(long_read_i),
        .cmd_o(read_cmd_o)
    );

    // RULE12 abort when inactive
    // RULE14 abort is the normal mode
    assign link_abort_o = link_access_i & ~link_clk_active_i & ~reg_q[`MBC_BIT_NO_ABORT];

    // link read data; suppressed abort answers all ones
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            link_rdata_o <= 32'h0000_0000;
        end else if (link_access_i) begin
            // RULE13 ones instead of abort
            if (!link_clk_active_i && reg_q[`MBC_BIT_NO_ABORT]) begin
                link_rdata_o <= `MBC_INACTIVE_DATA;
            end else begin
                link_rdata_o <= link_core_rdata_i;
            end
        end
    end

    // RULE15 io lines to two-wire
    assign twowire_route_o = reg_q[`MBC_BIT_TWOWIRE];
    assign twowire_clk_o = general_io_line_three_i;
    assign twowire_data_o = general_io_line_two_i;
    // pins float while routed, so the two-wire master sees the line
    assign general_io_line_three_o = general_io_line_three_drv_i;
    assign general_io_line_two_o = general_io_line_two_drv_i;
    assign general_io_line_three_oe_n_o = twowire_route_o | general_io_line_three_oen_n_i;
    assign general_io_line_two_oe_n_o = twowire_route_o | general_io_line_two_oen_n_i;

    // RULE16 link clock bypass
    assign link_clk_gate_bypass_o = reg_q[`MBC_BIT_LINK_BYP];
    // RULE17 host clock bypass
    assign host_clk_gate_bypass_o = reg_q[`MBC_BIT_HOST_BYP];
    // RULE18 keep host clock
    assign keep_host_clk_o = reg_q[`MBC_BIT_KEEP_CLK];
endmodule

//--- mbc_host_model.sv
`timescale 1ns/1ps
// config-space master; released lines carry the inverse so stale values never match
module mbc_host_model (
    input logic clk_i,
    input logic [31:0] cfg_rdata_i,
    output logic cfg_wr_o = '0,
    output logic cfg_rd_o = '0,
    output logic [7:0] cfg_addr_o = '0,
    output logic [3:0] cfg_be_o = '0,
    output logic [31:0] cfg_wdata_o = '0
);
    task wr(logic [7:0] a, logic [3:0] b, logic [31:0] w);
        @(negedge clk_i) {cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = {1'b1, a, b, w};
        @(negedge clk_i) {cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = {1'b0, ~a, ~b, ~w};
    endtask
    // read data is registered, so it is settled one falling edge after the strobe
    task rd(logic [7:0] a, output logic [31:0] d);
        @(negedge clk_i) {cfg_rd_o, cfg_addr_o} = {1'b1, a};
        @(negedge clk_i) {cfg_rd_o, cfg_addr_o} = {1'b0, ~a};
        d = cfg_rdata_i;
    endtask
endmodule

//--- mbc_misc_reg_sva.sv
`timescale 1ns/1ps
module mbc_misc_reg_sva (
    input logic clk_i,
    input logic resetn_i,
    input logic cfg_rd_i,
    input logic [7:0] cfg_addr_i,
    input logic [31:0] cfg_rdata_o,
    input logic [2:0] pm_revision_field_o,
    input logic vendor_id_bit26_o,
    input logic pme_from_deep_off_support_o,
    input logic global_irq_enable_i,
    input logic unmasked_irq_i,
    input logic pme_req_o,
    input logic long_read_i,
    input logic [3:0] read_cmd_o,
    input logic link_access_i,
    input logic link_clk_active_i,
    input logic link_abort_o,
    input logic [31:0] link_rdata_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // read hits tie the returned word to the decoded side outputs
    wire rd_hit = cfg_rd_i && cfg_addr_i == 8'hf0;
    wire [18:0] fixed_bits = {cfg_rdata_o[31:16], cfg_rdata_o[11], cfg_rdata_o[6:5]};
    wire gate_open = global_irq_enable_i || vendor_id_bit26_o;
    wire quiet_idle = link_access_i && !link_clk_active_i && !link_abort_o;
    a_rsvd_zero: assert property (rd_hit |=> fixed_bits == 19'h0_0004)
        else $error("fixed bits wrong");
    a_pm_rev: assert property (rd_hit |=> pm_revision_field_o == {2'b01, cfg_rdata_o[7]})
        else $error("pm revision wrong");
    a_vendor_mirror: assert property (rd_hit |=> vendor_id_bit26_o == cfg_rdata_o[10])
        else $error("vendor bit wrong");
    a_deep_off: assert property (rd_hit |=>
        pme_from_deep_off_support_o == cfg_rdata_o[15])
        else $error("deep-off bit wrong");
    a_pme_raise: assert property (unmasked_irq_i && gate_open |=> pme_req_o)
        else $error("pme missing");
    a_pme_block: assert property (unmasked_irq_i && !gate_open |=> !pme_req_o)
        else $error("pme not gated");
    a_short_plain: assert property (!long_read_i |=> read_cmd_o == 4'h6)
        else $error("short read command");
    a_idle_ones: assert property (quiet_idle |=> link_rdata_o == 32'hffff_ffff)
        else $error("idle link data");
endmodule
bind mbc_misc_reg mbc_misc_reg_sva u_sva (.*);

//--- tb_misc_bus_config_register.sv
`timescale 1ns/1ps
module tb_misc_bus_config_register;
    logic clk_i = 0, resetn_i = 0, ee_load_i = 0, long_read_i = 0, link_access_i = 0;
    logic link_clk_active_i = 1, cfg_wr_i, cfg_rd_i, cfg_hit_o, pme_req_o, link_abort_o;
    logic global_irq_enable_i, unmasked_irq_i, vendor_id_bit26_o, pme_from_deep_off_support_o;
    logic power_level_pin_2_o, power_level_pin_1_o, power_level_pin_0_o, twowire_route_o;
    logic general_io_line_three_i, general_io_line_two_i, general_io_line_three_drv_i;
    logic general_io_line_two_drv_i, general_io_line_three_oen_n_i, general_io_line_two_oen_n_i;
    logic general_io_line_three_o, general_io_line_two_o, general_io_line_three_oe_n_o;
    logic general_io_line_two_oe_n_o, twowire_clk_o, twowire_data_o, keep_host_clk_o;
    logic link_clk_gate_bypass_o, host_clk_gate_bypass_o;
    logic [2:0] pm_revision_field_o;
    logic [3:0] cfg_be_i, read_cmd_o, b;
    logic [7:0] cfg_addr_i, ee_word_i;
    logic [15:0] ee_data_i = 16'hfffe;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, link_rdata_o, link_core_rdata_i, d, ex, w;
    logic [31:0] rnd = '0;
    int bad_count = 0, tests_run = 0, cyc = 0;
    // side inputs wander every cycle so pme gating and pin routing see both levels
    assign {global_irq_enable_i, unmasked_irq_i, general_io_line_three_i, general_io_line_two_i,
        general_io_line_three_drv_i, general_io_line_two_drv_i, general_io_line_three_oen_n_i,
        general_io_line_two_oen_n_i} = rnd[7:0];
    assign link_core_rdata_i = rnd;
    wire [5:0] outs = {twowire_route_o, general_io_line_three_oe_n_o, general_io_line_two_oe_n_o,
        link_clk_gate_bypass_o, host_clk_gate_bypass_o, keep_host_clk_o};
    wire [7:0] pins = {pme_from_deep_off_support_o, power_level_pin_2_o, power_level_pin_1_o,
        power_level_pin_0_o, pm_revision_field_o, keep_host_clk_o};
    mbc_misc_reg dut (.*);
    mbc_host_model host (.clk_i(clk_i), .cfg_rdata_i(cfg_rdata_o), .cfg_wr_o(cfg_wr_i),
        .cfg_rd_o(cfg_rd_i), .cfg_addr_o(cfg_addr_i), .cfg_be_o(cfg_be_i),
        .cfg_wdata_o(cfg_wdata_i));
    always #50 clk_i = ~clk_i;
    always @(negedge clk_i) rnd <= $urandom;
    // hang guard, far above the few hundred cycles of traffic
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end
    // expected image: only writable lanes move, reserved and fixed bits stay
    function automatic logic [31:0] nx(logic [31:0] o, logic [3:0] be, logic [31:0] v);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & 32'h0000_f79f;
        return (o & ~m) | (v & m);
    endfunction
    task chk(string n, logic [31:0] e, logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("ERROR %s exp %h got %h", n, e, s);
            bad_count++;
        end
    endtask
    task end_sim();
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        void'($urandom(60421));
        repeat (4) @(negedge clk_i);
        resetn_i = 1;
        host.rd(8'hf0, d);
        chk("reset", 32'h0000_0800, d);
        host.wr(8'hf0, 4'hf, '1);
        host.rd(8'hf0, d);
        chk("ones", 32'h0000_ff9f, d);
        chk("outs", 32'h3f, 32'(outs));
        // suppression on: an idle link completes with ones, then aborts once cleared
        {link_clk_active_i, link_access_i} = 2'b01;
        #1 chk("abort", 0, link_abort_o);
        @(negedge clk_i) link_access_i = 0;
        chk("ldata", '1, link_rdata_o);
        host.wr(8'hf0, 4'h1, '0);
        link_access_i = 1;
        #1 chk("abort", 1, link_abort_o);
        @(negedge clk_i) {link_clk_active_i, link_access_i} = 2'b10;
        // every selector code, the reserved one included
        for (int s = 0; s < 4; s++) begin
            host.wr(8'hf0, 4'h2, 32'(s) << 8);
            long_read_i = 1;
            @(negedge clk_i) long_read_i = 0;
            chk("cmd", 32'(s == 1 ? 4'h6 : s == 2 ? 4'hc : 4'he), 32'(read_cmd_o));
        end
        // a neighbouring word must leave the field alone
        {ee_word_i, ee_load_i} = {8'h0d, 1'b1};
        @(negedge clk_i) ee_load_i = 0;
        host.rd(8'hf0, d);
        chk("ee_other", 32'h0000_0b00, d);
        {ee_word_i, ee_load_i} = {8'h0c, 1'b1};
        @(negedge clk_i) ee_load_i = 0;
        ex = 32'h0000_0a00;
        host.rd(8'hf0, d);
        chk("eeprom", ex, d);
        // random traffic keeps the test-only and suppress bits clear
        repeat (40) begin
            w = $urandom & 32'hffff_ffe9;
            b = 4'($urandom);
            host.wr(8'hf0, b, w);
            ex = nx(ex, b, w);
            host.rd(8'hf0, d);
            chk("image", ex, d);
            chk("pins", 32'({ex[15:12], 2'b01, ex[7], ex[0]}), 32'(pins));
            // pin routing settles after the falling-edge update of the wandering inputs
            #1 chk("gpio", 32'({rnd[5:2], rnd[1:0] | {2{ex[3]}}}), 32'({twowire_clk_o,
                twowire_data_o, general_io_line_three_o, general_io_line_two_o,
                general_io_line_three_oe_n_o, general_io_line_two_oe_n_o}));
        end
        host.rd(8'hf4, d);
        chk("miss", 0, d);
        chk("hit", 0, cfg_hit_o);
        resetn_i = 0;
        @(negedge clk_i) resetn_i = 1;
        host.rd(8'hf0, d);
        chk("greset", 32'h0000_0800, d);
        end_sim();
    end
endmodule
